//--- hdl/gtm_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gtm_edge_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // Two-stage synchroniser, third stage only for edge detection
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Edges seen from settled stages only
    assign o_rise = sync_r & ~last_r;
    assign o_fall = ~sync_r & last_r;

endmodule : gtm_edge_sync

`default_nettype wire

//--- hdl/gtm_map.svh
// How it works
// - Capture mode select low picks edge counting rather than edge timing.
// - Edge event select chooses rising, falling or both edges to count.
// - Each qualifying edge decrements the counter by one until match.
// - On match: raw flag set, masked flag set only where its mask bit is set, reload, run enable cleared.
// - No prescaler in edge count, edge timing or PWM modes.
// - Edge timing: free-running down-count from load, 0xFFFF after reset.
// - Capture mode select high enters edge timing mode.
// - Selected edge (rising when both are selected) copies count to capture register and sets capture flags.
// - Capture register holds its value until the next selected edge.
// - Edge timing keeps counting after capture; reloads from load at zero.
// - PWM counts down, reloads at zero, repeats, raises no flags.
// - PWM output sets at load value, clears at match value.
// - PWM invert bit inverts the driven waveform.
// - Writing a timeout clear bit clears raw and masked timeout status.
// - RTC: on match the counter reloads zero and keeps counting.
// - One-shot stops after timeout; periodic keeps counting.
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// Global configuration values
`define GTM_CFG_32BIT 3'h0
`define GTM_CFG_RTC 3'h1
`define GTM_CFG_16BIT 3'h4
// Timer mode field values
`define GTM_MODE_ONESHOT 2'h1
`define GTM_MODE_PERIODIC 2'h2
`define GTM_MODE_CAPTURE 2'h3
// Edge event select values
`define GTM_EVT_RISE 2'h0
`define GTM_EVT_FALL 2'h1
`define GTM_EVT_BOTH 2'h3
// Reset and start values
`define GTM_LOAD_RST 32'hFFFFFFFF
`define GTM_CNT_RST 32'hFFFFFFFF
`define GTM_MATCH_RST 32'hFFFFFFFF
`define GTM_PSC_RST 8'h00
`define GTM_RTC_START 32'h00000001
`define GTM_RTC_ZERO 32'h00000000
// RTC input rate and one-second divider
`define GTM_RTC_IN_HZ 32768
`define GTM_RTC_OUT_HZ 1
`define GTM_RTC_DIV (`GTM_RTC_IN_HZ / `GTM_RTC_OUT_HZ)

`endif

//--- hdl/gtm_pkg.sv
`default_nettype none
package gtm_pkg;

    // Decoded operating mode
    typedef enum logic [2:0] {
        OP_OFF   = 3'b000,
        OP_PER32 = 3'b001,
        OP_RTC   = 3'b010,
        OP_PER16 = 3'b011,
        OP_ECNT  = 3'b100,
        OP_ETIME = 3'b101,
        OP_PWM   = 3'b110
    } gtm_op_t;

    // Status flags, raw or masked
    typedef struct packed {
        logic rtc;
        logic cap_event;
        logic cap_match;
        logic timeout;
    } gtm_flags_t;

    // Static configuration bits
    typedef struct packed {
        logic [2:0] global_cfg;
        logic [1:0] mode_field;
        logic capture_mode_select;
        logic alternate_mode_select;
        logic [1:0] event_select;
        logic pwm_output_invert;
        logic rtc_stall_override;
        logic stall;
    } gtm_ctrl_t;

endpackage : gtm_pkg

`default_nettype wire

//--- hdl/gtm_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtm_map.svh"

module gtm_timer #(
    parameter int unsigned P_RTC_DIV = `GTM_RTC_DIV
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire gtm_pkg::gtm_ctrl_t i_ctrl,
    input wire logic i_en_set,
    input wire logic i_en_clr,
    input wire logic [31:0] i_load_value,
    input wire logic i_load_wr,
    input wire logic [31:0] i_match_value,
    input wire logic i_match_wr,
    input wire logic [7:0] i_prescale_value,
    input wire logic i_prescale_wr,
    input wire gtm_pkg::gtm_flags_t i_mask,
    input wire gtm_pkg::gtm_flags_t i_clear,
    input wire logic i_ccp_in,
    output logic o_ccp_out,
    output logic o_ccp_oe_n,
    output logic o_run_enable,
    output logic [31:0] o_count,
    output logic [15:0] o_capture,
    output gtm_pkg::gtm_flags_t o_raw,
    output gtm_pkg::gtm_flags_t o_masked
);

    // Mode decode from configuration, mode field and capture bits
    function automatic gtm_pkg::gtm_op_t decode_op(
        input gtm_pkg::gtm_ctrl_t c
    );
        gtm_pkg::gtm_op_t op;
        op = gtm_pkg::OP_OFF;
        if (c.global_cfg == `GTM_CFG_32BIT) begin
            if (c.mode_field == `GTM_MODE_ONESHOT ||
                c.mode_field == `GTM_MODE_PERIODIC) begin
                op = gtm_pkg::OP_PER32;
            end
        end else if (c.global_cfg == `GTM_CFG_RTC) begin
            op = gtm_pkg::OP_RTC;
        end else if (c.global_cfg == `GTM_CFG_16BIT) begin
            if (c.alternate_mode_select &&
                !c.capture_mode_select &&
                c.mode_field == `GTM_MODE_PERIODIC) begin
                op = gtm_pkg::OP_PWM;
            end else if (c.mode_field == `GTM_MODE_CAPTURE) begin
                // Low selects counting, high selects timing
                op = c.capture_mode_select ? gtm_pkg::OP_ETIME
                                           : gtm_pkg::OP_ECNT;
            end else if (c.mode_field == `GTM_MODE_ONESHOT ||
                         c.mode_field == `GTM_MODE_PERIODIC) begin
                op = gtm_pkg::OP_PER16;
            end
        end
        return op;
    endfunction : decode_op

    // Down-step of the 16-bit or 32-bit counter
    function automatic logic [31:0] step_down(
        input logic [31:0] v,
        input logic wide
    );
        logic [15:0] low;
        low = v[15:0] - 16'h0001;
        return wide ? (v - 32'h00000001) : {16'h0000, low};
    endfunction : step_down

    gtm_pkg::gtm_op_t op;
    logic rise;
    logic fall;
    logic wide;
    logic at_zero;
    logic stall_eff;
    logic cnt_edge;
    logic time_edge;
    logic ecnt_hit;
    logic [15:0] cnt16;
    logic [31:0] load_ext;

    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] load_r, load_nxt;
    logic [31:0] match_r, match_nxt;
    logic [7:0] psc_val_r, psc_val_nxt;
    logic [7:0] psc_r, psc_nxt;
    logic [15:0] cap_r, cap_nxt;
    logic [15:0] div_r, div_nxt;
    logic en_r, en_nxt;
    logic pwm_r, pwm_nxt;
    logic pin_r, pin_nxt;
    logic oe_n_r, oe_n_nxt;
    logic rtc_seen_r, rtc_seen_nxt;
    gtm_pkg::gtm_flags_t ev;
    gtm_pkg::gtm_flags_t raw_r, raw_nxt;
    gtm_pkg::gtm_flags_t msk_r, msk_nxt;

    // Pin crosses into the clock domain before any use
    gtm_edge_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_pin(i_ccp_in),
        .o_rise(rise),
        .o_fall(fall)
    );

    // Shared decode terms
    always_comb begin
        op = decode_op(i_ctrl);
        wide = (op == gtm_pkg::OP_PER32) || (op == gtm_pkg::OP_RTC);
        cnt16 = cnt_r[15:0];
        at_zero = wide ? (cnt_r == 32'h00000000) : (cnt16 == 16'h0000);
        load_ext = wide ? load_r : {16'h0000, load_r[15:0]};
        // RTC keeps running through a stall when the override is set
        stall_eff = i_ctrl.stall &&
                    !(op == gtm_pkg::OP_RTC && i_ctrl.rtc_stall_override);
        case (i_ctrl.event_select)
            `GTM_EVT_RISE: cnt_edge = rise;
            `GTM_EVT_FALL: cnt_edge = fall;
            `GTM_EVT_BOTH: cnt_edge = rise | fall;
            default: cnt_edge = rise;
        endcase
        // Timing takes one edge type only; both falls back to rising
        time_edge = (i_ctrl.event_select == `GTM_EVT_FALL) ? fall
                                                          : rise;
        ecnt_hit = (op == gtm_pkg::OP_ECNT) && en_r && !stall_eff &&
                   !i_load_wr && cnt_edge &&
                   (step_down(cnt_r, 1'b0) ==
                    {16'h0000, match_r[15:0]});
    end

    // Next-state of counter, enable, capture, waveform and flags
    always_comb begin
        cnt_nxt = cnt_r;
        load_nxt = i_load_wr ? i_load_value : load_r;
        match_nxt = i_match_wr ? i_match_value : match_r;
        psc_val_nxt = i_prescale_wr ? i_prescale_value : psc_val_r;
        psc_nxt = psc_r;
        cap_nxt = cap_r;
        div_nxt = div_r;
        en_nxt = en_r;
        pwm_nxt = pwm_r;
        rtc_seen_nxt = rtc_seen_r;
        ev = '0;
        if (i_en_clr) begin
            en_nxt = 1'b0;
        end
        if (i_en_set) begin
            en_nxt = 1'b1;
        end
        if (i_en_set && !en_r && op == gtm_pkg::OP_RTC && !rtc_seen_r) begin
            // First RTC start counts up from one
            cnt_nxt = `GTM_RTC_START;
            rtc_seen_nxt = 1'b1;
            div_nxt = 16'h0000;
        end else if (i_load_wr && op != gtm_pkg::OP_RTC) begin
            // New interval takes effect on the next cycle
            cnt_nxt = wide ? i_load_value : {16'h0000, i_load_value[15:0]};
            psc_nxt = psc_val_nxt;
        end else if (en_r && !stall_eff) begin
            case (op)
                gtm_pkg::OP_PER32, gtm_pkg::OP_PER16: begin
                    // Prescaler only extends the 16-bit timeout modes
                    if (op == gtm_pkg::OP_PER32 || psc_r == 8'h00) begin
                        psc_nxt = psc_val_r;
                        if (at_zero) begin
                            cnt_nxt = load_ext;
                            ev.timeout = 1'b1;
                            if (i_ctrl.mode_field == `GTM_MODE_ONESHOT) begin
                                en_nxt = 1'b0;
                            end
                        end else begin
                            cnt_nxt = step_down(cnt_r, wide);
                        end
                    end else begin
                        psc_nxt = psc_r - 8'h01;
                    end
                end
                gtm_pkg::OP_ECNT: begin
                    // One step per qualifying edge, no prescale
                    if (ecnt_hit) begin
                        cnt_nxt = load_ext;
                        ev.cap_match = 1'b1;
                        en_nxt = 1'b0;
                    end else if (cnt_edge) begin
                        cnt_nxt = step_down(cnt_r, 1'b0);
                    end
                end
                gtm_pkg::OP_ETIME: begin
                    if (time_edge) begin
                        cap_nxt = cnt16;
                        ev.cap_event = 1'b1;
                    end
                    cnt_nxt = at_zero ? load_ext
                                      : step_down(cnt_r, 1'b0);
                end
                gtm_pkg::OP_PWM: begin
                    cnt_nxt = at_zero ? load_ext
                                      : step_down(cnt_r, 1'b0);
                    if (cnt16 == load_r[15:0]) begin
                        pwm_nxt = 1'b1;
                    end else if (cnt16 == match_r[15:0]) begin
                        pwm_nxt = 1'b0;
                    end
                end
                gtm_pkg::OP_RTC: begin
                    // Pin clock divided down to one tick per second
                    if (rise) begin
                        if (div_r == 16'(P_RTC_DIV - 1)) begin
                            div_nxt = 16'h0000;
                            if (cnt_r == match_r) begin
                                cnt_nxt = `GTM_RTC_ZERO;
                                ev.rtc = 1'b1;
                            end else begin
                                cnt_nxt = cnt_r + 32'h00000001;
                            end
                        end else begin
                            div_nxt = div_r + 16'h0001;
                        end
                    end
                end
                default: cnt_nxt = cnt_r;
            endcase
        end
        // Hardware set beats a clear in the same cycle
        raw_nxt = ev | (raw_r & ~i_clear);
        msk_nxt = raw_nxt & i_mask;
        pin_nxt = pwm_nxt ^ i_ctrl.pwm_output_invert;
        oe_n_nxt = (op != gtm_pkg::OP_PWM);
    end

    // State registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= `GTM_CNT_RST;
            load_r <= `GTM_LOAD_RST;
            match_r <= `GTM_MATCH_RST;
            psc_val_r <= `GTM_PSC_RST;
            psc_r <= `GTM_PSC_RST;
            cap_r <= 16'h0000;
            div_r <= 16'h0000;
            en_r <= 1'b0;
            pwm_r <= 1'b0;
            pin_r <= 1'b0;
            oe_n_r <= 1'b1;
            rtc_seen_r <= 1'b0;
            raw_r <= '0;
            msk_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            load_r <= load_nxt;
            match_r <= match_nxt;
            psc_val_r <= psc_val_nxt;
            psc_r <= psc_nxt;
            cap_r <= cap_nxt;
            div_r <= div_nxt;
            en_r <= en_nxt;
            pwm_r <= pwm_nxt;
            pin_r <= pin_nxt;
            oe_n_r <= oe_n_nxt;
            rtc_seen_r <= rtc_seen_nxt;
            raw_r <= raw_nxt;
            msk_r <= msk_nxt;
        end
    end

    assign o_ccp_out = pin_r;
    assign o_ccp_oe_n = oe_n_r;
    assign o_run_enable = en_r;
    assign o_count = cnt_r;
    assign o_capture = cap_r;
    assign o_raw = raw_r;
    assign o_masked = msk_r;

    // Checks of the counting modes
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    ecnt_match_stop_a: assert property (
        ecnt_hit && !i_en_set |=> !o_run_enable && o_raw.cap_match &&
            o_count[15:0] == $past(load_r[15:0]))
        else $error("edge count match did not stop and reload");
    ecnt_ignore_a: assert property (
        ecnt_hit && !i_en_set ##1 (!i_en_set && !i_load_wr) [*2] |->
            $stable(o_count))
        else $error("edge counter moved after match");
    ecnt_step_a: assert property (
        op == gtm_pkg::OP_ECNT && en_r && !stall_eff && !i_load_wr &&
        cnt_edge && !ecnt_hit |=>
            o_count[15:0] == $past(cnt16) - 16'h0001)
        else $error("edge count did not step by one");
    cap_copy_a: assert property (
        op == gtm_pkg::OP_ETIME && en_r && !stall_eff && !i_load_wr &&
        time_edge |=> o_capture == $past(cnt16) && o_raw.cap_event)
        else $error("capture did not copy the count");
    cap_hold_a: assert property (
        !(op == gtm_pkg::OP_ETIME && en_r && time_edge) |=>
            $stable(o_capture))
        else $error("capture changed without an edge");
    etime_reload_a: assert property (
        op == gtm_pkg::OP_ETIME && en_r && !stall_eff && !i_load_wr &&
        at_zero |=> o_count[15:0] == $past(load_r[15:0]))
        else $error("edge timer missed its reload at zero");
    pwm_edges_a: assert property (
        op == gtm_pkg::OP_PWM && en_r && !stall_eff && !i_load_wr &&
        cnt16 == match_r[15:0] && cnt16 != load_r[15:0] &&
        $stable(i_ctrl) |=> ##1 o_ccp_out == i_ctrl.pwm_output_invert)
        else $error("pwm output did not drop at match");
    pwm_quiet_a: assert property (
        op == gtm_pkg::OP_PWM && $stable(op) |=>
            !$rose(o_raw.cap_match) && !$rose(o_raw.cap_event) &&
            !$rose(o_raw.timeout))
        else $error("pwm mode raised a status flag");
    to_clear_a: assert property (
        i_clear.timeout && !ev.timeout |=>
            !o_raw.timeout && !o_masked.timeout)
        else $error("timeout clear did not clear status");
    oneshot_stop_a: assert property (
        ev.timeout && i_ctrl.mode_field == `GTM_MODE_ONESHOT && !i_en_set
        |=> !o_run_enable)
        else $error("one-shot kept running after timeout");
    rtc_wrap_a: assert property (
        ev.rtc && !i_en_clr |=> o_count == `GTM_RTC_ZERO && o_run_enable)
        else $error("rtc did not wrap to zero");

    // Main scenarios
    ecnt_done_c: cover property (ecnt_hit ##[1:20] i_en_set);
    cap_twice_c: cover property (ev.cap_event ##[1:50] ev.cap_event);
    pwm_cycle_c: cover property ($rose(pwm_r) ##[1:100] $fell(pwm_r));
    rtc_wrap_c: cover property (ev.rtc);

endmodule : gtm_timer

`default_nettype wire

//--- tb/gtm_pin_src.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side source of edges on the capture pin
module gtm_pin_src (
    input wire logic i_clk_sys,
    output logic o_pin
);
    initial o_pin = 1'b0;

    // Each new level is held whole clocks, never fewer than two
    task automatic toggle(input int n, input int hold);
        repeat (n) begin
            @(posedge i_clk_sys);
            o_pin <= ~o_pin;
            repeat ((hold < 2 ? 2 : hold) - 1) @(posedge i_clk_sys);
        end
    endtask : toggle
endmodule : gtm_pin_src

`default_nettype wire

//--- tb/gtm_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtm_map.svh"

module gtm_timer_tb_top;
    localparam int HOLD = 12;
    localparam int STEPS [3] = '{1, 1, 8};
    localparam logic [1:0] EVS [3] = '{`GTM_EVT_RISE, `GTM_EVT_FALL,
        `GTM_EVT_BOTH};
    logic i_clk_sys, i_rst, i_en_set, i_en_clr, i_load_wr, i_match_wr;
    logic i_prescale_wr, i_ccp_in, o_ccp_out, o_ccp_oe_n, o_run_enable;
    logic src_pin;
    gtm_pkg::gtm_ctrl_t i_ctrl;
    gtm_pkg::gtm_flags_t i_mask, i_clear, o_raw, o_masked;
    logic [31:0] i_load_value, i_match_value, o_count, seed;
    logic [7:0] i_prescale_value;
    logic [15:0] o_capture;
    int mismatches, compares, d, l, m, t, e, n, c1, hi;

    // Pin level: the design owns the wire only while its enable is low
    assign i_ccp_in = o_ccp_oe_n ? src_pin : o_ccp_out;

    gtm_timer #(.P_RTC_DIV(4)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_ctrl(i_ctrl), .i_en_set(i_en_set), .i_en_clr(i_en_clr),
        .i_load_value(i_load_value), .i_load_wr(i_load_wr),
        .i_match_value(i_match_value), .i_match_wr(i_match_wr),
        .i_prescale_value(i_prescale_value), .i_prescale_wr(i_prescale_wr),
        .i_mask(i_mask), .i_clear(i_clear), .i_ccp_in(i_ccp_in),
        .o_ccp_out(o_ccp_out), .o_ccp_oe_n(o_ccp_oe_n),
        .o_run_enable(o_run_enable), .o_count(o_count),
        .o_capture(o_capture), .o_raw(o_raw), .o_masked(o_masked));

    gtm_pin_src src (.i_clk_sys(i_clk_sys), .o_pin(src_pin));

    // 250 MHz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // Xorshift keeps every run repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Qualifying edges after t toggles from a low pin
    function automatic int edges(input logic [1:0] ev, input int t);
        if (ev == `GTM_EVT_RISE) return (t + 1) / 2;
        if (ev == `GTM_EVT_FALL) return t / 2;
        return t;
    endfunction : edges

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    // Disable, configure, load, then enable; flags cleared on the way
    task automatic setup(input gtm_pkg::gtm_ctrl_t c, input logic [31:0] lv,
            input logic [31:0] mv, input logic [7:0] p);
        logic [31:0] r;
        r = rnd();
        @(posedge i_clk_sys);
        i_en_clr <= 1'b1;
        i_clear <= 4'hF;
        i_mask <= r[3:0];
        @(posedge i_clk_sys);
        i_en_clr <= 1'b0;
        i_clear <= 4'h0;
        i_ctrl <= c;
        i_load_value <= lv;
        i_match_value <= mv;
        i_prescale_value <= p;
        i_load_wr <= 1'b1;
        i_match_wr <= 1'b1;
        i_prescale_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_load_wr <= 1'b0;
        i_match_wr <= 1'b0;
        i_prescale_wr <= 1'b0;
        i_en_set <= 1'b1;
        @(posedge i_clk_sys);
        i_en_set <= 1'b0;
        #1;
    endtask : setup

    task automatic clr(input logic [3:0] f);
        @(posedge i_clk_sys);
        i_clear <= f;
        @(posedge i_clk_sys);
        i_clear <= 4'h0;
        #1;
    endtask : clr

    // Bounded wait for the timeout flag; cycles counted in k
    task automatic wait_to(output int k);
        k = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end while (o_raw.timeout !== 1'b1 && k < 5000);
        if (o_raw.timeout !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask : wait_to

    initial begin
        seed = 32'h0000BB3E;
        {i_rst, i_en_set, i_en_clr, i_load_wr, i_match_wr} = 5'h1F;
        {i_en_set, i_en_clr, i_load_wr, i_match_wr, i_prescale_wr} = 5'h00;
        {i_ctrl, i_mask, i_clear} = 20'h00000;
        {i_load_value, i_match_value, i_prescale_value} = 72'h0;
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1;
        check(o_count, 32'hFFFFFFFF);
        check({o_run_enable, o_ccp_oe_n, o_raw, o_capture}, 22'h100000);
        $display("test reset complete");
        // Edge counting for every edge selection, extra edges ignored
        for (int k = 0; k < 3; k++) begin
            d = 1 + rnd() % 4;
            l = d + rnd() % 200;
            setup({`GTM_CFG_16BIT, `GTM_MODE_CAPTURE, 2'b00, EVS[k], 3'h0},
                l, l - d, 8'(rnd()));
            t = 0;
            foreach (STEPS[s]) begin
                src.toggle(STEPS[s], HOLD);
                t += STEPS[s];
                #1;
                e = edges(EVS[k], t);
                check(o_count, e >= d ? l : l - e);
                check(o_run_enable, e < d);
            end
            check(o_raw.cap_match, 1'b1);
            check(o_masked.cap_match, i_mask.cap_match);
            clr(4'h2);
            check({o_raw.cap_match, o_masked.cap_match}, 2'b00);
            $display("test edge count %0d complete", k);
        end
        // Edge timing: free-running count, captures on rising edges
        l = 40 + rnd() % 60;
        setup({`GTM_CFG_16BIT, `GTM_MODE_CAPTURE, 2'b10, `GTM_EVT_RISE,
            3'h0}, l, 0, 8'(rnd()));
        repeat (2 * l) begin
            c1 = int'(o_count);
            @(posedge i_clk_sys);
            #1;
            check(o_count, c1 == 0 ? l : c1 - 1);
        end
        src.toggle(1, HOLD);
        #1;
        c1 = int'(o_capture);
        check(o_raw.cap_event, 1'b1);
        check(o_masked.cap_event, i_mask.cap_event);
        src.toggle(1, HOLD);
        #1;
        check(o_capture, c1);
        src.toggle(1, HOLD);
        #1;
        check(o_capture, (c1 + l + 1 - 2 * HOLD) % (l + 1));
        $display("test edge time complete");
        // PWM duty over whole periods, both polarities, on the wire
        for (int inv = 0; inv < 2; inv++) begin
            l = 10 + rnd() % 30;
            m = 1 + rnd() % (l - 1);
            setup({`GTM_CFG_16BIT, `GTM_MODE_PERIODIC, 2'b01, 2'b00,
                1'(inv), 2'b00}, l, m, 8'(rnd()));
            repeat (2 * (l + 1)) @(posedge i_clk_sys);
            hi = 0;
            repeat (3 * (l + 1)) begin
                @(posedge i_clk_sys);
                #1;
                hi += int'(i_ccp_in === 1'b1);
            end
            check(hi, inv ? 3 * (m + 1) : 3 * (l - m));
            check(o_ccp_oe_n, 1'b0);
            check(o_raw, 4'h0);
            $display("test pwm %0d complete", inv);
        end
        // One-shot and periodic timers, 16 and 32 bit
        for (int i = 0; i < 4; i++) begin
            d = i < 2 ? rnd() % 4 : 0;
            l = 20 + rnd() % 30;
            setup({i < 2 ? `GTM_CFG_16BIT : `GTM_CFG_32BIT,
                i[0] ? `GTM_MODE_PERIODIC : `GTM_MODE_ONESHOT, 7'h00},
                l, 0, 8'(d));
            wait_to(n);
            check(o_masked.timeout, i_mask.timeout);
            clr(4'h1);
            check({o_raw.timeout, o_masked.timeout}, 2'b00);
            if (i[0]) begin
                wait_to(n);
                check(n + 2, (l + 1) * (d + 1));
                check(o_run_enable, 1'b1);
            end else begin
                repeat (5) @(posedge i_clk_sys);
                #1;
                check(o_run_enable, 1'b0);
                check(o_count, 32'(l));
            end
            $display("test timer %0d complete", i);
        end
        // RTC with stall held and overridden, match 3
        setup({`GTM_CFG_RTC, 7'h00, 2'b11}, 0, 3, 8'h00);
        @(posedge i_clk_sys);
        #1;
        check(o_count, `GTM_RTC_START);
        c1 = 1;
        repeat (6) begin
            src.toggle(8, 3);
            repeat (6) @(posedge i_clk_sys);
            #1;
            c1 = c1 == 3 ? 0 : c1 + 1;
            check(o_count, c1);
            check(o_run_enable, 1'b1);
            if (c1 == 0) check(o_raw.rtc, 1'b1);
        end
        // Without the override a stall freezes the clock
        @(posedge i_clk_sys);
        i_ctrl.rtc_stall_override <= 1'b0;
        src.toggle(8, 3);
        repeat (6) @(posedge i_clk_sys);
        #1;
        check(o_count, c1);
        $display("test rtc complete");
        summarize();
    end
endmodule : gtm_timer_tb_top

`default_nettype wire
